// >>> pms_slave.sv
/*
 * Paged two-wire serial memory slave: byte receive/transmit, address
 * counter, two-byte page buffer and nonvolatile programming interval.
 * Assumes scl and sda come from the bus master asynchronously and are
 * sampled by clk; sda is open drain, pulled high outside the design.
 */
`timescale 1ns/1ps
`include "pms_cfg.svh"

// Function
// - First byte after a write address byte is the target memory address.
// - At most one two-byte page accepted per write transaction.
// - Address counter advances after every received data byte.
// - Pages are two bytes aligned on even addresses.
// - Excess write bytes wrap to the start of the current page.
// - After a page write stop, device programs during the interval.
// - Device leaves its slave address unacknowledged while programming.
// - Programming writes the whole two-byte page.
// - Unmodified byte of a page keeps its previous value.
// - Reads start from the current address counter.
// - Address-only write loads the counter and stores nothing.
// - Device keeps sending while master acknowledges each byte.
// - Traffic after a foreign address is ignored until next start.
// - Three slave address bits come from the select pins.
// - Bytes go MSB first; ninth bit 0 acknowledges, 1 refuses.
module pms_slave
    import pms_pkg::*;
#(
    parameter int MEM_AW   = `PMS_MEM_AW,
    parameter int PROG_CYC = `PMS_NVPROG_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl,
    input  wire logic sda_i,
    output logic      sda_o,
    output logic      sda_oe,
    input  wire logic addr_select_bit0,
    input  wire logic addr_select_bit1,
    input  wire logic addr_select_bit2,
    output logic      busy
);

    initial begin
        if (MEM_AW < 2 || MEM_AW > 8 || PROG_CYC < 1)
            $error("pms_slave: unsupported parameter values");
    end

    // ------------------------------------------------------------------
    // Pin synchronisers and bus event detection
    // ------------------------------------------------------------------
    logic [1:0] scl_s_q;
    logic [1:0] sda_s_q;
    logic       scl_p_q;
    logic       sda_p_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s_q <= 2'h3;
            sda_s_q <= 2'h3;
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl};
            sda_s_q <= {sda_s_q[0], sda_i};
            scl_p_q <= scl_s_q[1];
            sda_p_q <= sda_s_q[1];
        end
    end

    wire scl_v    = scl_s_q[1];
    wire sda_v    = sda_s_q[1];
    wire scl_rise = scl_v & ~scl_p_q;
    wire scl_fall = ~scl_v & scl_p_q;
    wire start_c  = scl_v & scl_p_q & sda_p_q & ~sda_v;
    wire stop_c   = scl_v & scl_p_q & ~sda_p_q & sda_v;

    // ------------------------------------------------------------------
    // Slave address and memory
    // ------------------------------------------------------------------
    wire [6:0] own_addr = {`PMS_ADDR_FIXED,
                           addr_select_bit2, addr_select_bit1, addr_select_bit0};

    function automatic logic [MEM_AW-1:0] page_next(input logic [MEM_AW-1:0] a);
        page_next = {a[MEM_AW-1:1], ~a[0]};
    endfunction : page_next

    logic [7:0] mem_q [0:(1<<MEM_AW)-1];
    logic [7:0] page_q [0:1];
    logic [MEM_AW-1:0] page_base_q;

    // ------------------------------------------------------------------
    // Transaction state
    // ------------------------------------------------------------------
    pms_state_t        st_q;
    logic [7:0]        sh_q;
    logic [3:0]        bit_q;
    logic              is_read_q;
    logic [1:0]        wbyte_q;
    logic              ack_q;
    logic [MEM_AW-1:0] addr_q;
    logic              dirty_q;
    logic              drive_q;
    logic              drv_val_q;
    logic [31:0]       prog_q;

    wire       byte_done = scl_rise && (bit_q == 4'h7);
    wire [7:0] rx_byte   = {sh_q[6:0], sda_v};
    wire       addr_hit  = (rx_byte[7:1] == own_addr) && !busy;
    wire       first_b   = (wbyte_q == 2'h0);
    wire       addr_b    = (wbyte_q == 2'h1);
    wire [MEM_AW-1:0] tx_addr = addr_q;

    assign busy   = (prog_q != 32'h0);
    assign sda_o  = 1'b0;
    assign sda_oe = drive_q & ~drv_val_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q        <= PMS_IDLE;
            sh_q        <= 8'h00;
            bit_q       <= 4'h0;
            is_read_q   <= 1'b0;
            wbyte_q     <= 2'h0;
            ack_q       <= 1'b0;
            addr_q      <= '0;
            dirty_q     <= 1'b0;
            drive_q     <= 1'b0;
            drv_val_q   <= 1'b1;
            prog_q      <= 32'h0;
            page_base_q <= '0;
            page_q[0]   <= 8'h00;
            page_q[1]   <= 8'h00;
        end else begin
            if (busy)
                prog_q <= prog_q - 32'h1;
            if (start_c) begin
                st_q    <= PMS_RX;
                bit_q   <= 4'h0;
                wbyte_q <= 2'h0;
                drive_q <= 1'b0;
            end else if (stop_c) begin
                st_q    <= PMS_IDLE;
                drive_q <= 1'b0;
                if (dirty_q) begin
                    dirty_q <= 1'b0;
                    prog_q  <= PROG_CYC;
                end
            end else begin
                unique case (st_q)
                    PMS_IDLE, PMS_IGNORE: begin
                    end
                    PMS_RX: begin
                        if (scl_rise) begin
                            sh_q  <= rx_byte;
                            bit_q <= bit_q + 4'h1;
                        end
                        if (byte_done) begin
                            ack_q <= 1'b1;
                            if (first_b) begin
                                is_read_q <= rx_byte[0];
                                if (!addr_hit)
                                    ack_q <= 1'b0;
                            end else if (addr_b) begin
                                addr_q <= rx_byte[MEM_AW-1:0];
                                page_base_q <= rx_byte[MEM_AW-1:0];
                                page_q[0] <= mem_q[{rx_byte[MEM_AW-1:1], 1'b0}];
                                page_q[1] <= mem_q[{rx_byte[MEM_AW-1:1], 1'b1}];
                            end else begin
                                page_q[addr_q[0]] <= rx_byte;
                                addr_q  <= page_next(addr_q);
                                dirty_q <= 1'b1;
                            end
                            if (wbyte_q != 2'h2)
                                wbyte_q <= wbyte_q + 2'h1;
                            st_q <= PMS_RX_ACK;
                        end
                    end
                    PMS_RX_ACK: begin
                        if (scl_fall && !drive_q) begin
                            if (ack_q) begin
                                drive_q   <= 1'b1;
                                drv_val_q <= 1'b0;
                            end else
                                st_q <= PMS_IGNORE;
                        end else if (scl_fall && drive_q) begin
                            bit_q <= 4'h0;
                            if (first_b || !is_read_q || !addr_b) begin
                                drive_q <= 1'b0;
                                st_q    <= PMS_RX;
                            end
                            if (is_read_q && addr_b) begin
                                sh_q      <= mem_q[tx_addr];
                                drv_val_q <= mem_q[tx_addr][7];
                                addr_q    <= addr_q + 1'b1;
                                st_q      <= PMS_TX;
                            end
                        end
                    end
                    PMS_TX: begin
                        if (scl_fall) begin
                            if (bit_q == 4'h7) begin
                                drive_q <= 1'b0;
                                st_q    <= PMS_TX_ACK;
                            end else begin
                                drv_val_q <= sh_q[6 - bit_q[2:0]];
                                bit_q     <= bit_q + 4'h1;
                            end
                        end
                    end
                    PMS_TX_ACK: begin
                        if (scl_rise) begin
                            if (sda_v)
                                st_q <= PMS_IGNORE;
                            else begin
                                sh_q      <= mem_q[tx_addr];
                                addr_q    <= addr_q + 1'b1;
                                bit_q     <= 4'h0;
                            end
                        end else if (scl_fall && !sda_p_q) begin
                            drive_q   <= 1'b1;
                            drv_val_q <= sh_q[7];
                            st_q      <= PMS_TX;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Nonvolatile commit of the whole page
    // ------------------------------------------------------------------
    wire commit = stop_c && dirty_q;

    always_ff @(posedge clk) begin
        if (commit) begin
            mem_q[{page_base_q[MEM_AW-1:1], 1'b0}] <= page_q[0];
            mem_q[{page_base_q[MEM_AW-1:1], 1'b1}] <= page_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_busy_load: assert property (@(posedge clk) disable iff (!rst_n)
        commit |=> (prog_q == PROG_CYC))
        else $error("programming interval not started");
    a_busy_nack: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_RX && byte_done && first_b && busy) |=> !ack_q)
        else $error("address acknowledged while busy");
    a_page_wrap: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_RX && byte_done && !first_b && !addr_b)
        |=> addr_q[MEM_AW-1:1] == $past(addr_q[MEM_AW-1:1]))
        else $error("write crossed page");
    a_addr_load: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_RX && byte_done && addr_b && !start_c && !stop_c)
        |=> addr_q == $past(rx_byte[MEM_AW-1:0]))
        else $error("address not loaded");
    a_foreign_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_IGNORE) |-> !sda_oe)
        else $error("drive while ignoring");
    a_ack_low: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_RX_ACK && drive_q) |-> sda_oe)
        else $error("ack not driven low");
    a_rd_incr: assert property (@(posedge clk) disable iff (!rst_n)
        (st_q == PMS_TX_ACK && scl_rise && !sda_v && !start_c && !stop_c)
        |=> addr_q == $past(addr_q) + 1'b1)
        else $error("read counter not advanced");
    a_busy_count: assert property (@(posedge clk) disable iff (!rst_n)
        (busy && !commit) |=> prog_q == $past(prog_q) - 32'h1)
        else $error("programming counter stalled");
    a_pin_addr: assert property (@(posedge clk) disable iff (!rst_n)
        own_addr[2:0] == {addr_select_bit2, addr_select_bit1, addr_select_bit0})
        else $error("select pins not used");

    c_write: cover property (@(posedge clk) disable iff (!rst_n) commit);
    c_read: cover property (@(posedge clk) disable iff (!rst_n) st_q == PMS_TX_ACK);
    c_poll: cover property (@(posedge clk) disable iff (!rst_n)
        st_q == PMS_RX && byte_done && first_b && busy);

endmodule : pms_slave

// >>> pms_cfg.svh
/*
 * Constants for the paged two-wire memory slave: address layout,
 * memory geometry and the programming interval.
 * Assumes inclusion by the package, the slave module and the test bench.
 */
`ifndef PMS_CFG_SVH
`define PMS_CFG_SVH

// ----------------------------------------------------------------------
// Geometry and addressing
// ----------------------------------------------------------------------
`define PMS_MEM_AW       4
`define PMS_ADDR_FIXED   4'hA
`define PMS_RW_WRITE     1'h0
`define PMS_RW_READ      1'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PMS_CLK_PERIOD_NS 10
`define PMS_NVPROG_US     10
`define PMS_NVPROG_CYC    ((`PMS_NVPROG_US * 1000) / `PMS_CLK_PERIOD_NS)

`endif

// >>> pms_pkg.sv
/*
 * Types for the paged two-wire memory slave.
 * Assumes pms_cfg.svh is on the include path.
 */
package pms_pkg;
`include "pms_cfg.svh"

    typedef enum logic [2:0] {
        PMS_IDLE,
        PMS_RX,
        PMS_RX_ACK,
        PMS_TX,
        PMS_TX_ACK,
        PMS_IGNORE
    } pms_state_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe;
    } pms_sda_drv_t;

endpackage : pms_pkg

// >>> pms_master_model.sv
/*
 * Behavioural two-wire bus master that stands opposite the memory slave.
 * Assumes the bench resolves the open-drain data line with a pull-up and
 * feeds the resolved level back on sda; each byte outcome is reported on
 * res with a one-cycle res_v pulse.
 */
`timescale 1ns/1ps
module pms_master_model (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_oe,
    output logic [7:0]      res,
    output logic            res_v
);
    initial begin
        scl    = 1'b1;
        sda_oe = 1'b0;
        res    = 8'h00;
        res_v  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic put(input logic [7:0] v);
        res   <= v;
        res_v <= 1'b1;
        tick(1);
        res_v <= 1'b0;
    endtask : put

    // --------------------------------------------------------------
    // Bit and framing primitives
    // --------------------------------------------------------------
    // Data changes only while the clock is low; sampled midway through high
    task automatic bit_io(input logic b, output logic r);
        scl    <= 1'b0;
        tick(4);
        sda_oe <= ~b;
        tick(4);
        scl    <= 1'b1;
        tick(4);
        r = sda;
        tick(4);
    endtask : bit_io

    task automatic start(input logic rep);
        if (rep) begin
            scl    <= 1'b0;
            tick(4);
            sda_oe <= 1'b0;
            tick(4);
            scl    <= 1'b1;
        end
        tick(8);
        sda_oe <= 1'b1;
        tick(8);
    endtask : start

    task automatic stop();
        scl    <= 1'b0;
        tick(4);
        sda_oe <= 1'b1;
        tick(4);
        scl    <= 1'b1;
        tick(8);
        sda_oe <= 1'b0;
        tick(8);
    endtask : stop

    // --------------------------------------------------------------
    // Byte transfers
    // --------------------------------------------------------------
    task automatic wbyte(input logic [7:0] b);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], a);
        end
        bit_io(1'b1, a);
        put({7'h00, a});
    endtask : wbyte

    task automatic rbyte(input logic last);
        logic [7:0] r;
        logic       x;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r[i]);
        end
        bit_io(last, x);
        put(r);
    endtask : rbyte
endmodule : pms_master_model

// >>> pms_slave_test.sv
/*
 * Self-checking bench for the paged two-wire memory slave.
 * Assumes the master model above and a pull-up on the data line.
 */
`timescale 1ns/1ps
`include "pms_cfg.svh"
module pms_slave_test;
    import pms_pkg::*;
    localparam int PROG = 400;
    logic       clk, rst_n, scl, sda_line, sda_o, sda_oe, m_oe, busy, res_v;
    logic [2:0] pins;
    logic [7:0] res;
    logic [7:0] q[$];
    int         n_errors = 0;
    int         n_compared = 0;

    assign sda_line = ~(m_oe | (sda_oe & ~sda_o));
    always #5 clk = ~clk;

    pms_slave #(.PROG_CYC(PROG)) u_dut (
        .clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe(sda_oe), .addr_select_bit0(pins[0]), .addr_select_bit1(pins[1]),
        .addr_select_bit2(pins[2]), .busy(busy)
    );
    pms_master_model m (
        .clk(clk), .sda(sda_line), .scl(scl), .sda_oe(m_oe), .res(res), .res_v(res_v)
    );

    // --------------------------------------------------------------
    // Checking helpers
    // --------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic conclude();
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        if (res_v === 1'b1) begin
            if (q.size() == 0) chk(res, 8'hEE);
            else chk(res, q.pop_front());
        end
    end

    function automatic logic [7:0] sa(input logic rd);
        return {`PMS_ADDR_FIXED, pins, rd};
    endfunction : sa

    task automatic wb(input logic [7:0] b, input logic nak);
        q.push_back({7'h00, nak});
        m.wbyte(b);
    endtask : wb

    task automatic rb(input logic [7:0] e, input logic last);
        q.push_back(e);
        m.rbyte(last);
    endtask : rb

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk({7'h00, busy}, 8'h00);
    endtask : wait_idle

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] d0, d1, d2, x6, x7, y;
        clk   = 1'b0;
        rst_n = 1'b0;
        pins  = 3'h0;
        void'($urandom(32'h7d69f9fa));
        d0 = 8'($urandom);
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        x6 = 8'($urandom);
        x7 = 8'($urandom);
        y  = 8'($urandom);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        pins  <= 3'($urandom);
        m.tick(6);
        m.start(0); wb({`PMS_ADDR_FIXED, ~pins, 1'b0}, 1'b1); m.stop();
        m.start(0); wb(sa(0), 0); wb(8'h04, 0); wb(d0, 0); wb(d1, 0);
        wb(d2, 0); m.stop();
        chk({7'h00, busy}, 8'h01);
        m.start(0); wb(sa(0), 1'b1); m.stop();
        wait_idle();
        m.start(0); wb(sa(0), 0); wb(8'h06, 0); wb(x6, 0); wb(x7, 0); m.stop();
        wait_idle();
        m.start(0); wb(sa(0), 0); wb(8'h07, 0); wb(y, 0); m.stop();
        wait_idle();
        m.start(0); wb(sa(0), 0); wb(8'h04, 0); m.start(1); wb(sa(1), 0);
        rb(d2, 0); rb(d1, 0); rb(x6, 0); rb(y, 1); m.stop();
        m.start(0); wb(sa(0), 0); wb(8'h05, 0); m.stop();
        chk({7'h00, busy}, 8'h00);
        m.start(0); wb(sa(1), 0); rb(d1, 1); m.stop();
        // Reset in mid-run cuts programming; new select pins afterwards
        m.start(0); wb(sa(0), 0); wb(8'h02, 0); wb(d0, 0); m.stop();
        rst_n <= 1'b0;
        m.tick(2);
        chk({7'h00, busy}, 8'h00);
        rst_n <= 1'b1;
        pins  <= 3'($urandom);
        m.tick(6);
        m.start(0); wb(sa(0), 0); wb(8'h02, 0); wb(d1, 0); m.stop();
        wait_idle();
        m.start(0); wb(sa(0), 0); wb(8'h02, 0); m.start(1); wb(sa(1), 0);
        rb(d1, 1); m.stop();
        m.tick(20);
        chk(8'(q.size()), 8'h00);
        conclude();
    end

    initial begin
        #500000;
        n_errors++;
        conclude();
    end
endmodule : pms_slave_test
